// ==== pkg/tofc_pkg.sv ====
// shared constants, types and helpers of the time-of-flight measurement control block
package tofc_pkg;

  // register map (byte addresses on the serial port)
  localparam logic [5:0] ADDR_SETUP_ONE   = 6'h00;
  localparam logic [5:0] ADDR_SETUP_TWO   = 6'h01;
  localparam logic [5:0] ADDR_EVENT_FLAGS = 6'h02;
  localparam logic [5:0] ADDR_EVENT_MASK  = 6'h03;
  localparam logic [5:0] ADDR_RESULT_BASE = 6'h10;
  localparam logic [5:0] ADDR_RESULT_LAST = 6'h1c;

  // reset values
  localparam logic [7:0] SETUP_ONE_RST = 8'h00;
  localparam logic [7:0] SETUP_TWO_RST = 8'h40;
  localparam logic [4:0] FLAGS_RST     = 5'h00;
  localparam logic [2:0] MASK_RST      = 3'h7;

  // event flag bit positions
  localparam int FLG_NEW      = 0;
  localparam int FLG_COARSE   = 1;
  localparam int FLG_CLK      = 2;
  localparam int FLG_STARTED  = 3;
  localparam int FLG_COMPLETE = 4;

  // command byte fields
  localparam int CMD_AUTOINC = 7;
  localparam int CMD_WRITE   = 6;

  // result store layout
  localparam int             RES_W     = 24;
  localparam int             RES_DEPTH = 13;
  localparam int             RES_AW    = 4;
  localparam logic [3:0]     CAL1_IDX  = 4'hb;
  localparam logic [3:0]     CAL2_IDX  = 4'hc;
  localparam logic [4:0]     SHORT_LAST = 5'h07;
  localparam logic [4:0]     LONG_LAST  = 5'h17;

  // configuration codes
  localparam logic [1:0] METHOD_ONE    = 2'b00;
  localparam logic [1:0] METHOD_TWO    = 2'b01;
  localparam logic [2:0] MAX_STOP_CODE = 3'b100;
  localparam logic [23:0] CAL1_PERIODS = 24'h000001;

  // timing
  localparam int REF_CLK_HZ = 20_000_000;
  localparam int TRIG_NS    = 200;
  localparam int TRIG_CYC   = (TRIG_NS * (REF_CLK_HZ / 1_000_000) + 999) / 1000;

  typedef struct packed {
    logic       force_cal;
    logic       parity_en;
    logic       trigger_out_polarity;
    logic       stop_pol;
    logic       start_pol;
    logic [1:0] measurement_method;
    logic       begin_measurement;
  } tofc_setup_one_t;

  typedef struct packed {
    logic [1:0] calibration_span;
    logic [2:0] averaging_count;
    logic [2:0] stop_count;
  } tofc_setup_two_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TRIG = 3'b001,
    ST_WAIT = 3'b011,
    ST_RUN  = 3'b010,
    ST_CAL  = 3'b110,
    ST_DONE = 3'b111
  } tofc_state_t;

  function automatic logic [23:0] tofc_span_periods(input logic [1:0] code);
    case (code)
      2'b00:   tofc_span_periods = 24'd2;
      2'b01:   tofc_span_periods = 24'd10;
      2'b10:   tofc_span_periods = 24'd20;
      default: tofc_span_periods = 24'd40;
    endcase
  endfunction

endpackage

// ==== rtl/tofc_result_mem.sv ====
// result store: per-entry registers with clear-all, accumulate and registered read
`timescale 1ns/100ps
module tofc_result_mem
  import tofc_pkg::*;
#(
  parameter int W     = RES_W,
  parameter int DEPTH = RES_DEPTH,
  parameter int AW    = RES_AW
) (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          clr_all,
  input  wire logic          we,
  input  wire logic          add,
  input  wire logic [AW-1:0] wa,
  input  wire logic [W-1:0]  wd,
  input  wire logic [AW-1:0] ra,
  output logic      [W-1:0]  rd_q
);

  logic [W-1:0] mem_q [DEPTH];

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_entry
      always_ff @(posedge ref_clk) begin
        if (rst || clr_all) begin
          mem_q[gi] <= '0;
        end else if (we && wa == AW'(gi)) begin
          mem_q[gi] <= add ? mem_q[gi] + wd : wd;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_q <= '0;
    end else begin
      rd_q <= (int'(ra) < DEPTH) ? mem_q[ra] : '0;
    end
  end

endmodule

// ==== rtl/tofc_measure_ctrl.sv ====
// time-of-flight measurement control: serial register port, sequencer and result store
// Summary of operation
// - without forced calibration, an interrupted measurement skips calibration
// - with forced calibration, calibration always runs, even after an overflow
// - parity enable gives even parity in result bit 23, otherwise zero
// - trigger polarity zero gives rising trigger edge, one gives falling
// - stop polarity zero ends timing on rising stop edge, one on falling
// - start polarity zero begins timing on rising start edge, one on falling
// - method code 00 is method one, code 01 is method two
// - begin bit clears itself at measurement end; writing 0 does nothing
// - writing begin as 1 clears all event flags
// - writing begin as 1 emits a trigger pulse with configured polarity
// - writing begin as 1 zeroes all result registers
// - calibration span codes give 2, 10, 20 or 40 periods; reset 01
// - averaging code n gives two to the n measurement cycles
// - stop count codes 000 to 100 capture one to five stops
// - stop count codes 101 to 111 act as single stop
// - completion and overflow set flags; host writes 1 to clear
// - counter overflow stops the measurement at once and records the flag
// - masked flags stay set but do not pull the interrupt pin low
`timescale 1ns/100ps
module tofc_measure_ctrl
  import tofc_pkg::*;
#(
  parameter logic [15:0] COARSE_OVF_LIMIT = 16'hffff,
  parameter logic [15:0] CLK_OVF_LIMIT    = 16'hffff
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic csb_n,
  input  wire logic sclk,
  input  wire logic din,
  output logic      dout,
  output logic      dout_oe,
  input  wire logic start_in,
  input  wire logic stop_in,
  output logic      trigger_out,
  output logic      irq_n_pin
);

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers: 0 csb, 1 sclk, 2 din, 3 start, 4 stop

  logic [4:0] pin_w;
  logic [4:0] sy1_q;
  logic [4:0] sy2_q;
  logic [4:0] prev_q;

  assign pin_w = {stop_in, start_in, din, sclk, csb_n};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          sy1_q[gi]  <= 1'b1;
          sy2_q[gi]  <= 1'b1;
          prev_q[gi] <= 1'b1;
        end else begin
          sy1_q[gi]  <= pin_w[gi];
          sy2_q[gi]  <= sy1_q[gi];
          prev_q[gi] <= sy2_q[gi];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // registers

  tofc_setup_one_t cfg1_q;
  tofc_setup_two_t cfg2_q;
  logic [4:0]      flags_q;
  logic [2:0]      mask_q;
  tofc_state_t     st_q;
  tofc_state_t     st_d;

  wire logic       csb_s      = sy2_q[0];
  wire logic       din_s      = sy2_q[2];
  wire logic       sclk_rise  = ~csb_s & sy2_q[1] & ~prev_q[1];
  wire logic       start_edge = (sy2_q[3] ^ cfg1_q.start_pol) &
                                ~(prev_q[3] ^ cfg1_q.start_pol);
  wire logic       stop_edge  = (sy2_q[4] ^ cfg1_q.stop_pol) &
                                ~(prev_q[4] ^ cfg1_q.stop_pol);

  //////////////////////////////////////////////////////////////////////////////
  // serial register port

  logic        cmd_ph_q;
  logic        done_q;
  logic        auto_q;
  logic        wr_q;
  logic        ld_q;
  logic [4:0]  bit_q;
  logic [5:0]  addr_q;
  logic [5:0]  ld_addr_q;
  logic [7:0]  sh_q;
  logic [23:0] out_q;
  logic [23:0] mem_rd;

  wire logic [7:0] byte_w    = {sh_q[6:0], din_s};
  wire logic [4:0] last_w    = (addr_q >= ADDR_RESULT_BASE) ? LONG_LAST : SHORT_LAST;
  wire logic       active_w  = sclk_rise & ~done_q;
  wire logic       data_rise = active_w & ~cmd_ph_q;
  wire logic       cmd_end   = active_w & cmd_ph_q & (bit_q == SHORT_LAST);
  wire logic       word_end  = data_rise & (bit_q == last_w);
  wire logic [5:0] nxt_addr  = cmd_ph_q ? byte_w[5:0] : addr_q + 6'd1;
  wire logic [5:0] ra_full   = nxt_addr - ADDR_RESULT_BASE;
  wire logic       wr_stb    = word_end & wr_q & (addr_q < ADDR_RESULT_BASE);
  wire logic       wr_cfg1   = wr_stb & (addr_q == ADDR_SETUP_ONE);
  wire logic       wr_cfg2   = wr_stb & (addr_q == ADDR_SETUP_TWO);
  wire logic       wr_flags  = wr_stb & (addr_q == ADDR_EVENT_FLAGS);
  wire logic       wr_mask   = wr_stb & (addr_q == ADDR_EVENT_MASK);
  wire logic       launch    = wr_cfg1 & byte_w[0];

  // read word selection, results carry parity in bit 23
  wire logic       res_addr  = (ld_addr_q >= ADDR_RESULT_BASE) &
                               (ld_addr_q <= ADDR_RESULT_LAST);
  wire logic       parity_w  = cfg1_q.parity_en & (^mem_rd[22:0]);
  logic [7:0]      cfg_rd;
  always_comb begin
    case (ld_addr_q)
      ADDR_SETUP_ONE:   cfg_rd = cfg1_q;
      ADDR_SETUP_TWO:   cfg_rd = cfg2_q;
      ADDR_EVENT_FLAGS: cfg_rd = {3'b000, flags_q};
      ADDR_EVENT_MASK:  cfg_rd = {5'b00000, mask_q};
      default:          cfg_rd = 8'h00;
    endcase
  end
  wire logic [23:0] rd_word = res_addr ? {parity_w, mem_rd[22:0]} : {cfg_rd, 16'h0000};

  always_ff @(posedge ref_clk) begin
    if (rst || csb_s) begin
      cmd_ph_q <= 1'b1;
      done_q   <= 1'b0;
      ld_q     <= 1'b0;
      bit_q    <= 5'd0;
    end else begin
      ld_q <= cmd_end ? ~byte_w[CMD_WRITE] : (word_end & auto_q & ~wr_q);
      if (cmd_end) begin
        cmd_ph_q <= 1'b0;
      end
      // one counter paces the command byte and then each data word
      if (active_w) begin
        bit_q <= (cmd_end | word_end) ? 5'd0 : bit_q + 5'd1;
      end
      if (word_end & ~auto_q) begin
        done_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      auto_q    <= 1'b0;
      wr_q      <= 1'b0;
      addr_q    <= 6'h00;
      ld_addr_q <= 6'h00;
      sh_q      <= 8'h00;
      out_q     <= 24'h000000;
    end else begin
      if (sclk_rise) begin
        sh_q <= byte_w;
      end
      if (cmd_end) begin
        auto_q <= byte_w[CMD_AUTOINC];
        wr_q   <= byte_w[CMD_WRITE];
        addr_q <= byte_w[5:0];
      end else if (word_end & auto_q) begin
        addr_q <= addr_q + 6'd1;
      end
      if (active_w) begin
        ld_addr_q <= nxt_addr;
      end
      if (ld_q) begin
        out_q <= rd_word;
      end else if (data_rise) begin
        out_q <= {out_q[22:0], 1'b0};
      end
    end
  end

  assign dout    = out_q[23];
  assign dout_oe = ~csb_s & ~cmd_ph_q & ~wr_q & ~done_q;

  //////////////////////////////////////////////////////////////////////////////
  // measurement sequencer

  logic [23:0] cnt_q;
  logic [2:0]  stops_q;
  logic [7:0]  cyc_q;
  logic        intr_q;

  wire logic        meth_one   = cfg1_q.measurement_method != METHOD_TWO;
  wire logic [23:0] limit_w    = {8'h00, meth_one ? COARSE_OVF_LIMIT : CLK_OVF_LIMIT};
  wire logic [2:0]  stop_last  = (cfg2_q.stop_count > MAX_STOP_CODE) ? 3'd0 :
                                 cfg2_q.stop_count;
  wire logic [7:0]  cyc_last   = 8'((9'd1 << cfg2_q.averaging_count) - 9'd1);
  wire logic [23:0] span_w     = tofc_span_periods(cfg2_q.calibration_span);
  wire logic        start_hit  = (st_q == ST_WAIT) & start_edge;
  wire logic        ovf_hit    = (st_q == ST_RUN) & (cnt_q == limit_w);
  wire logic        stop_hit   = (st_q == ST_RUN) & stop_edge & ~ovf_hit;
  wire logic        last_stop  = stop_hit & (stops_q == stop_last);
  wire logic        cal_one    = (st_q == ST_CAL) & (cnt_q == CAL1_PERIODS);
  wire logic        cal_end    = (st_q == ST_CAL) & (cnt_q == span_w);

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: st_d = ST_IDLE;
      ST_TRIG: if (cnt_q == 24'(TRIG_CYC - 1)) st_d = ST_WAIT;
      ST_WAIT: if (start_hit) st_d = ST_RUN;
      ST_RUN: begin
        if (ovf_hit) begin
          st_d = cfg1_q.force_cal ? ST_CAL : ST_DONE;
        end else if (last_stop) begin
          st_d = (cyc_q == cyc_last) ? ST_CAL : ST_TRIG;
        end
      end
      ST_CAL:  if (cal_end) st_d = ST_DONE;
      ST_DONE: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q    <= ST_IDLE;
      cnt_q   <= 24'h000000;
      stops_q <= 3'd0;
      cyc_q   <= 8'd0;
      intr_q  <= 1'b0;
    end else begin
      st_q    <= launch ? ST_TRIG : st_d;
      cnt_q   <= (launch || st_d != st_q) ? 24'h000000 : cnt_q + 24'd1;
      stops_q <= (launch || start_hit) ? 3'd0 : stops_q + {2'b00, stop_hit};
      cyc_q   <= launch ? 8'd0 : cyc_q + {7'd0, last_stop};
      intr_q  <= launch ? 1'b0 : (intr_q | ovf_hit);
    end
  end

  // trigger idles at the polarity level and pulses toward the opposite one
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      trigger_out <= 1'b0;
    end else begin
      trigger_out <= cfg1_q.trigger_out_polarity ^ (st_q == ST_TRIG);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // result store; each cycle adds its share so the sum is the average

  wire logic        mem_we  = stop_hit | cal_one | cal_end;
  wire logic [3:0]  mem_wa  = (st_q == ST_CAL) ? (cal_end ? CAL2_IDX : CAL1_IDX) :
                              {stops_q, ~meth_one};
  wire logic [23:0] mem_wd  = (st_q == ST_CAL) ? cnt_q : (cnt_q >> cfg2_q.averaging_count);
  wire logic        mem_add = (st_q == ST_RUN) & (cyc_q != 8'd0);

  tofc_result_mem #(
    .W     (RES_W),
    .DEPTH (RES_DEPTH),
    .AW    (RES_AW)
  ) u_results (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clr_all (launch),
    .we      (mem_we),
    .add     (mem_add),
    .wa      (mem_wa),
    .wd      (mem_wd),
    .ra      (ra_full[3:0]),
    .rd_q    (mem_rd)
  );

  //////////////////////////////////////////////////////////////////////////////
  // configuration, flags and interrupt pin

  wire logic [4:0] set_w = {st_q == ST_DONE,
                            start_hit,
                            ovf_hit & ~meth_one,
                            ovf_hit & meth_one,
                            st_q == ST_DONE};
  wire logic [4:0] clr_w = wr_flags ? byte_w[4:0] : 5'h00;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg1_q  <= SETUP_ONE_RST;
      cfg2_q  <= SETUP_TWO_RST;
      flags_q <= FLAGS_RST;
      mask_q  <= MASK_RST;
    end else begin
      if (wr_cfg1) begin
        cfg1_q <= {byte_w[7:1], cfg1_q.begin_measurement | byte_w[0]};
      end else if (st_q == ST_DONE) begin
        cfg1_q.begin_measurement <= 1'b0;
      end
      if (wr_cfg2) begin
        cfg2_q <= byte_w;
      end
      if (wr_mask) begin
        mask_q <= byte_w[2:0];
      end
      flags_q <= launch ? 5'h00 : ((flags_q & ~clr_w) | set_w);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_n_pin <= 1'b1;
    end else begin
      irq_n_pin <= ~|(flags_q[2:0] & mask_q);
    end
  end

endmodule

// ==== sim/tofc_measure_ctrl_chk.sv ====
// port-level checks of the measurement control block
`timescale 1ns/100ps
module tofc_measure_ctrl_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic csb_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic trigger_out,
  input wire logic irq_n_pin
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  sequence s_trig_hold;
    $stable(trigger_out) [*3];
  endsequence
  sequence s_sclk_recent;
    $past(sclk, 2);
  endsequence
  property p_trig_width;
    $changed(trigger_out) |=> s_trig_hold;
  endproperty
  a_trig_width: assert property (p_trig_width) else $error("trigger pulse short");
  property p_rst_idle;
    disable iff (1'b0) rst |=> !trigger_out && irq_n_pin && !dout_oe;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle in reset");
  property p_irq_sticky;
    !irq_n_pin && csb_n |=> !irq_n_pin;
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("flag lost without host");
  property p_irq_clear;
    $rose(irq_n_pin) |-> !$past(csb_n, 3);
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq released by itself");
  property p_oe_csb;
    csb_n [*4] |-> !dout_oe;
  endproperty
  a_oe_csb: assert property (p_oe_csb) else $error("dout driven while deselected");
  property p_oe_sel;
    $rose(dout_oe) |-> !csb_n;
  endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("dout enabled without select");
  property p_oe_rise;
    $rose(dout_oe) |-> s_sclk_recent;
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("dout enable off clock edge");
  property p_dout_step;
    dout_oe && $past(dout_oe) && $changed(dout) |-> s_sclk_recent;
  endproperty
  a_dout_step: assert property (p_dout_step) else $error("dout moved off clock edge");
endmodule
bind tofc_measure_ctrl tofc_measure_ctrl_chk u_chk (.ref_clk(ref_clk), .rst(rst),
  .csb_n(csb_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe),
  .start_in(start_in), .stop_in(stop_in), .trigger_out(trigger_out), .irq_n_pin(irq_n_pin));

// ==== sim/tofc_host_model.sv ====
// host side: serial register master and start/stop pulse source
`timescale 1ns/100ps
module tofc_host_model (
  input  wire logic ref_clk,
  input  wire logic dout,
  output logic      csb_n,
  output logic      sclk,
  output logic      din,
  output logic      start_in,
  output logic      stop_in
);
  initial begin
    csb_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
    start_in = 1'b0;
    stop_in = 1'b0;
  end
  ////////////////////////////////////////
  // one frame, msb first; clock rests low between frames
  task automatic frame(input logic [31:0] tx, input int nb, output logic [31:0] rx);
    rx = 32'h0;
    @(negedge ref_clk);
    csb_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      din = tx[31 - i];
      repeat (4) @(negedge ref_clk);
      rx = {rx[30:0], dout};
      sclk = 1'b1;
      repeat (4) @(negedge ref_clk);
      sclk = 1'b0;
    end
    repeat (4) @(negedge ref_clk);
    csb_n = 1'b1;
    din = ~din; // released line shows no stale bit
    repeat (4) @(negedge ref_clk);
  endtask
  // start edge at step 4, stop k edge at step 14 + 12k; lines rest inactive
  task automatic shot(input int n, input logic stp, input logic spp);
    for (int t = 0; t < 74; t++) begin
      @(negedge ref_clk);
      start_in = stp ^ (t >= 4 && t < 10);
      stop_in = spp ^ (t >= 14 && (t - 14) % 12 < 6 && (t - 14) / 12 < n);
    end
  endtask
endmodule

// ==== sim/tofc_measure_ctrl_test.sv ====
// self-checking bench of the measurement control block
`timescale 1ns/100ps
module tofc_measure_ctrl_test
  import tofc_pkg::*;
;
  logic        ref_clk;
  logic        rst;
  logic        csb_n;
  logic        sclk;
  logic        din;
  logic        dout;
  logic        dout_oe;
  logic        start_in;
  logic        stop_in;
  logic        trigger_out;
  logic        irq_n_pin;
  logic        tmon;
  logic        tpol;
  int          twid;
  int          npulse;
  int          cyc;
  int          num_errors;
  int          total_checks;
  int          seed;
  int          r;
  logic [23:0] v;
  logic [31:0] w;
  // a released data pin shows the inverse of its last bit, so a late sample is caught
  wire logic   dout_line = dout_oe ? dout : ~dout;
  logic [5:0]  ra [6] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h1c, 6'h3f};
  logic [7:0]  re [6] = '{8'h00, 8'h40, 8'h00, 8'h07, 8'h00, 8'h00};
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  tofc_measure_ctrl #(.COARSE_OVF_LIMIT(16'h0040), .CLK_OVF_LIMIT(16'h0040)) dut (
    .ref_clk(ref_clk), .rst(rst), .csb_n(csb_n), .sclk(sclk), .din(din), .dout(dout),
    .dout_oe(dout_oe), .start_in(start_in), .stop_in(stop_in), .trigger_out(trigger_out),
    .irq_n_pin(irq_n_pin));
  tofc_host_model u_host (.ref_clk(ref_clk), .dout(dout_line), .csb_n(csb_n), .sclk(sclk),
    .din(din), .start_in(start_in), .stop_in(stop_in));
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  function automatic logic [22:0] span_exp(input logic [1:0] c);
    span_exp = (c == 2'b00) ? 23'd2 : 23'd10 << (c - 2'b01);
  endfunction
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [31:0] x;
    u_host.frame({2'b01, a, d, 16'h0}, 16, x);
  endtask
  task automatic rd(input logic [5:0] a, output logic [23:0] d);
    logic [31:0] x;
    u_host.frame({2'b00, a, 24'h0}, (a >= ADDR_RESULT_BASE) ? 32 : 16, x);
    d = (a >= ADDR_RESULT_BASE) ? x[23:0] : {16'h0, x[7:0]};
  endtask
  // trigger pulse width, counted away from the idle level
  always @(posedge ref_clk) begin
    if (tmon && trigger_out !== tpol) begin
      twid <= twid + 1;
    end else if (twid != 0) begin
      chk("trigger width", TRIG_CYC, twid);
      npulse <= npulse + 1;
      twid <= 0;
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      conclude();
    end
  end
  // config changes only while idle; method codes limited to 00 and 01
  task automatic run(input logic [7:0] c1, input logic [7:0] c2, input logic ovf);
    logic [2:0]  m;
    logic [7:0]  e;
    logic [22:0] d;
    int          ns;
    int          lo;
    int          hi;
    r = $random(seed);
    m = r[2:0];
    e = {3'h0, 2'b11, ovf & c1[1], ovf & ~c1[1], 1'b1};
    ns = (c2[2:0] > MAX_STOP_CODE) ? 1 : c2[2:0] + 1;
    tmon = 1'b0;
    wr(ADDR_EVENT_MASK, {5'h0, m});
    wr(ADDR_SETUP_TWO, c2);
    wr(ADDR_SETUP_ONE, c1);
    tpol = c1[5];
    tmon = 1'b1;
    npulse = 0;
    wr(ADDR_SETUP_ONE, c1 | 8'h01);
    rd(ADDR_EVENT_FLAGS, v);
    chk("flags after begin", 0, v);
    rd(ADDR_RESULT_LAST, v);
    chk("result after begin", 0, v);
    wr(ADDR_SETUP_ONE, c1);
    rd(ADDR_SETUP_ONE, v);
    chk("begin after zero write", c1 | 8'h01, v);
    for (int c = 0; c < (1 << c2[5:3]); c++) begin
      for (int i = 0; i < 2000 && npulse <= c; i++) @(negedge ref_clk);
      u_host.shot(ovf ? 0 : 5, c1[3], c1[4]);
    end
    v = 24'h1;
    for (int i = 0; i < 40 && v[0] !== 1'b0; i++) rd(ADDR_SETUP_ONE, v);
    chk("begin self clear", 0, v[0]);
    chk("trigger count", 1 << c2[5:3], npulse);
    rd(ADDR_EVENT_FLAGS, v);
    chk("event flags", e, v);
    chk("interrupt pin", ~|(e[2:0] & m), irq_n_pin);
    rd({2'b01, CAL1_IDX}, v);
    chk("cal one", (ovf & ~c1[7]) ? 0 : {c1[6], 23'd1}, v);
    d = span_exp(c2[7:6]);
    rd({2'b01, CAL2_IDX}, v);
    chk("cal two", (ovf & ~c1[7]) ? 0 : {c1[6] & ^d, d}, v);
    for (int k = 0; k < 10 && k < 2 * ns + 2 && !ovf; k++) begin
      rd(6'(ADDR_RESULT_BASE + k), v);
      lo = 0;
      hi = 0;
      // each averaging cycle adds its truncated share of a 10 + 12(k/2) cycle interval
      if (k % 2 == int'(c1[1]) && k / 2 < ns) begin
        lo = ((7 + 12 * (k / 2)) >> c2[5:3]) << c2[5:3];
        hi = ((13 + 12 * (k / 2)) >> c2[5:3]) << c2[5:3];
      end
      chk("result parity", c1[6] & ^v[22:0], v[23]);
      chk("result value", lo,
          (v[22:0] >= lo && v[22:0] <= hi) ? lo : v[22:0]);
    end
    wr(ADDR_EVENT_FLAGS, 8'h18);
    rd(ADDR_EVENT_FLAGS, v);
    chk("flags after clear", e & 8'h07, v);
  endtask
  initial begin
    seed = 32'h6bcbaddc;
    rst = 1'b1;
    tmon = 1'b0;
    tpol = 1'b0;
    twid = 0;
    npulse = 0;
    cyc = 0;
    num_errors = 0;
    total_checks = 0;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    repeat (3) @(negedge ref_clk);
    wr(6'h3f, 8'hff);
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], v);
      chk("reset value", re[i], v);
    end
    // auto-increment read of both setup registers in one frame
    u_host.frame({2'b10, ADDR_SETUP_ONE, 24'h0}, 24, w);
    chk("autoinc read", {SETUP_ONE_RST, SETUP_TWO_RST}, w[15:0]);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      run({r[4:0], 1'b0, i[0], 1'b0}, {r[6:5], (i == 7) ? 3'd7 : 3'(i % 4), 3'(i)}, 1'b0);
    end
    r = $random(seed);
    run({1'b0, r[3:0], 3'b000}, {r[5:4], 6'h0}, 1'b1);
    run({1'b1, r[7:4], 3'b010}, {r[9:8], 6'h0}, 1'b1);
    conclude();
  end
endmodule
